/* verification/ppm_peripheral.sv */
// peripheral model on the far side of the port pins
// assumes its tasks are called from the ref_clk domain
`timescale 1ns/1ns
module ppm_peripheral (
    input  wire logic  ref_clk,
    output logic [7:0] portAIn,
    output logic [7:0] portBIn,
    output logic       portAStrobeIn,
    output logic       portBStrobeIn,
    output logic       portAAuxIn,
    output logic       portBAuxIn
);
    initial
    begin
        portAIn = 8'h00;
        portBIn = 8'h00;
        portAStrobeIn = 1'b0;
        portBStrobeIn = 1'b0;
        portAAuxIn = 1'b0;
        portBAuxIn = 1'b0;
    end

    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : step

    // strobe level after lag + 1 cycles; a long lag is a slow answer
    task automatic strobe(input logic onA, input logic v, input int lag);
        step(lag + 1);
        if (onA)
            portAStrobeIn = v;
        else
            portBStrobeIn = v;
    endtask : strobe

    // present a byte pair, strobe it in, then let the lines drift
    task automatic send(input logic [7:0] a, input logic [7:0] b, input int lag);
        step(1);
        portAIn = a;
        portBIn = b;
        strobe(1'b0, 1'b1, lag);
        strobe(1'b0, 1'b0, 1);
        step(1);
        portAIn = ~a;
        portBIn = ~b;
        portAAuxIn = ~portAAuxIn;
    endtask : send
endmodule : ppm_peripheral

/* verification/tb.sv */
// self-checking bench for the parallel port mode selector
// assumes the package, interface, buffer and top are compiled first
`timescale 1ns/1ns
`define CHK(got, exp) \
    begin \
        cmpCount++; \
        if ((got) !== (exp)) \
        begin \
            errCount++; \
            $display("wrong value at %0t: got %h expected %h", $time, got, exp); \
        end \
    end
module tb;
    logic        ref_clk = 1'b0;
    logic        rst = 1'b1;
    logic [1:0]  portMode, portASubmode, portBSubmode, portAAuxRole, portBAuxRole, rdMask;
    logic [7:0]  portADir, portBDir, portAIn, portBIn, portAOut, portBOut, portAOe, portBOe;
    logic [7:0]  portASample, portBSample;
    logic        portAAuxLevel, portBAuxLevel, portAStrobeIn, portBStrobeIn;
    logic        portAAuxIn, portBAuxIn, portAAuxOut, portAAuxOe, portBAuxOut, portBAuxOe;
    logic        wrValid, wrReady, rdValid, rdReady;
    logic [15:0] wrData, rdData;
    logic [3:0]  statusEdge;
    int          errCount = 0;
    int          cmpCount = 0;

    always #5 ref_clk = ~ref_clk;

    ppm_top u_dut (
        .ref_clk(ref_clk), .rst(rst), .portMode(portMode), .portASubmode(portASubmode),
        .portBSubmode(portBSubmode), .portADir(portADir), .portBDir(portBDir),
        .portAAuxRole(portAAuxRole), .portBAuxRole(portBAuxRole),
        .portAAuxLevel(portAAuxLevel), .portBAuxLevel(portBAuxLevel),
        .portAIn(portAIn), .portAOut(portAOut), .portAOe(portAOe), .portBIn(portBIn),
        .portBOut(portBOut), .portBOe(portBOe), .portAStrobeIn(portAStrobeIn),
        .portBStrobeIn(portBStrobeIn), .portAAuxIn(portAAuxIn), .portAAuxOut(portAAuxOut),
        .portAAuxOe(portAAuxOe), .portBAuxIn(portBAuxIn), .portBAuxOut(portBAuxOut),
        .portBAuxOe(portBAuxOe), .wrValid(wrValid), .wrData(wrData), .wrReady(wrReady),
        .rdValid(rdValid), .rdMask(rdMask), .rdData(rdData), .rdReady(rdReady),
        .portASample(portASample), .portBSample(portBSample), .statusEdge(statusEdge)
    );

    ppm_peripheral u_per (
        .ref_clk(ref_clk), .portAIn(portAIn), .portBIn(portBIn),
        .portAStrobeIn(portAStrobeIn), .portBStrobeIn(portBStrobeIn),
        .portAAuxIn(portAAuxIn), .portBAuxIn(portBAuxIn)
    );

    task automatic tallyAndFinish;
        $display("compares %0d mismatches %0d", cmpCount, errCount);
        if (errCount == 0 && cmpCount > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : tallyAndFinish

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : cyc

    task automatic setup(input logic [1:0] m, input logic [1:0] sa, input logic [1:0] sb,
                         input logic [7:0] da, input logic [7:0] db);
        portMode = m;
        portASubmode = sa;
        portBSubmode = sb;
        portADir = da;
        portBDir = db;
        cyc(2);
    endtask : setup

    task automatic write_word(input logic [15:0] w);
        wrValid = 1'b1;
        wrData = w;
        for (int i = 0; i < 20 && wrReady !== 1'b1; i++)
            cyc(1);
        cyc(1);
        wrValid = 1'b0;
    endtask : write_word

    task automatic read_word(input logic [1:0] m, input logic [15:0] d, input logic [15:0] c);
        for (int i = 0; i < 20 && rdValid !== 1'b1; i++)
            cyc(1);
        `CHK(rdMask, m)
        `CHK(rdData & c, d)
        rdReady = 1'b1;
        cyc(1);
        rdReady = 1'b0;
    endtask : read_word

    task automatic test_latch8;
        setup(2'h0, 2'h2, 2'h0, 8'h00, 8'h00);
        u_per.send(8'h77, 8'h3C, 2);
        read_word(2'h1, 16'h003C, 16'h00FF);
        cyc(3);
        `CHK(rdValid, 1'b0)
        `CHK(portASample, 8'h88)
        `CHK(portBSample, 8'hC3)
        $display("latched byte test done");
    endtask : test_latch8

    task automatic test_outputs;
        portAAuxRole = 2'h1;
        setup(2'h0, 2'h2, 2'h1, 8'hFF, 8'hFF);
        write_word(16'h5AC3);
        `CHK(portAOut, 8'h5A)
        cyc(1);
        `CHK(portBOut, 8'hC3)
        `CHK({portAAuxOe, portAAuxOut}, 2'h3)
        write_word(16'h1234);
        cyc(2);
        `CHK(wrReady, 1'b0)
        `CHK(portBOut, 8'hC3)
        `CHK(portAOut, 8'h12)
        u_per.strobe(1'b0, 1'b1, 4);
        for (int i = 0; i < 6 && portBOut !== 8'h34; i++)
            cyc(1);
        `CHK(portBOut, 8'h34)
        u_per.strobe(1'b0, 1'b0, 0);
        cyc(3);
        `CHK(wrReady, 1'b1)
        u_per.strobe(1'b1, 1'b1, 0);
        for (int i = 0; i < 4 && statusEdge[3] !== 1'b1; i++)
            cyc(1);
        `CHK(statusEdge, 4'h8)
        cyc(1);
        `CHK(statusEdge[3], 1'b0)
        u_per.strobe(1'b1, 1'b0, 0);
        $display("output buffering test done");
    endtask : test_outputs

    task automatic test_word16;
        portBAuxRole = 2'h2;
        setup(2'h1, 2'h1, 2'h0, 8'h00, 8'h00);
        u_per.send(8'hA1, 8'hB1, 0);
        u_per.send(8'hA2, 8'hB2, 3);
        u_per.send(8'hA3, 8'hB3, 0);
        cyc(2);
        `CHK(portBAuxOut, 1'b0)
        u_per.send(8'hEE, 8'hEE, 0);
        read_word(2'h3, 16'hA1B1, 16'hFFFF);
        read_word(2'h3, 16'hA2B2, 16'hFFFF);
        read_word(2'h3, 16'hA3B3, 16'hFFFF);
        cyc(3);
        `CHK(rdValid, 1'b0)
        `CHK(portBAuxOut, 1'b1)
        $display("word buffer test done");
    endtask : test_word16

    task automatic test_bidir;
        for (int m = 2; m < 4; m++)
        begin
            setup(m[1:0], 2'h0, 2'h0, 8'h0F, 8'h00);
            u_per.strobe(1'b1, 1'b1, 0);
            cyc(2);
            `CHK(portBOe, 8'hFF)
            `CHK(portAOe, (m == 3) ? 8'hFF : 8'h0F)
            u_per.strobe(1'b1, 1'b0, 0);
            cyc(2);
            `CHK(portBOe, 8'h00)
            `CHK(portAOe, (m == 3) ? 8'h00 : 8'h0F)
        end
        $display("bidirectional driver test done");
    endtask : test_bidir

    task automatic test_pulse;
        portAAuxRole = 2'h3;
        setup(2'h2, 2'h0, 2'h0, 8'h00, 8'h00);
        write_word(16'h00A5);
        cyc(2);
        `CHK(portBOut, 8'hA5)
        `CHK(portAAuxOut, 1'b1)
        cyc(2);
        `CHK(portAAuxOut, 1'b1)
        cyc(1);
        `CHK(portAAuxOut, 1'b0)
        portBAuxRole = 2'h1;
        setup(2'h0, 2'h0, 2'h2, 8'h00, 8'h00);
        `CHK({portBAuxOe, portBAuxOut}, 2'h2)
        $display("pulsed handshake test done");
    endtask : test_pulse

    initial
    begin
        #50000;
        errCount++;
        tallyAndFinish();
    end

    initial
    begin
        portMode = 2'h0;
        portASubmode = 2'h0;
        portBSubmode = 2'h0;
        portADir = 8'h00;
        portBDir = 8'h00;
        portAAuxRole = 2'h0;
        portBAuxRole = 2'h0;
        portAAuxLevel = 1'b1;
        portBAuxLevel = 1'b0;
        wrValid = 1'b0;
        wrData = 16'h0000;
        rdReady = 1'b0;
        repeat (5) @(posedge ref_clk);
        #1;
        rst = 1'b0;
        cyc(1);
        test_latch8();
        test_outputs();
        test_word16();
        test_bidir();
        test_pulse();
        tallyAndFinish();
    end
endmodule : tb

/* verilog/ppm_buffer.sv */
// two-entry buffer between the input latches and the host read side
// assumes one clock, synchronous active-high reset
`timescale 1ns/1ns
module ppm_buffer (
    input  wire logic    ref_clk,
    input  wire logic    rst,
    ppm_stream_if.snk    inPort,
    ppm_stream_if.src    outPort
);
    logic                 headValid;
    logic                 tailValid;
    ppm_pkg::ppm_entry_t  head;
    ppm_pkg::ppm_entry_t  tail;
    logic                 pop;
    logic                 push;
    logic                 keepHead;

    assign pop = headValid & outPort.ready;
    assign push = inPort.valid & ~tailValid;
    assign keepHead = headValid & ~pop;
    assign inPort.ready = ~tailValid;
    assign outPort.valid = headValid;
    assign outPort.data = head;

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            headValid <= 1'b0;
            tailValid <= 1'b0;
        end
        else if (keepHead)
        begin
            if (push)
                tailValid <= 1'b1;
        end
        else
        begin
            headValid <= tailValid | push;
            tailValid <= tailValid & push;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            head <= '0;
            tail <= '0;
        end
        else
        begin
            if (!keepHead)
                head <= tailValid ? tail : inPort.data;
            if (push)
                tail <= inPort.data;
        end
    end

    // a stalled reader sees its word held
    head_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
        headValid && !outPort.ready |=> headValid && $stable(head))
        else $error("buffer head changed while stalled");
endmodule : ppm_buffer

/* verilog/ppm_defines.svh */
// constants of the parallel port mode selector: codes, field positions, timing
// assumes inclusion by bare name from the package and the design modules
`ifndef PPM_DEFINES_SVH
`define PPM_DEFINES_SVH
`define PPM_MODE_UNI8          2'h0
`define PPM_MODE_UNI16         2'h1
`define PPM_MODE_BID8          2'h2
`define PPM_MODE_BID16         2'h3
`define PPM_SUB_SIMPLE_BIT     1
`define PPM_SUB_OUTDBL_BIT     0
`define PPM_AUX_STATUS         2'h0
`define PPM_AUX_GPOUT          2'h1
`define PPM_AUX_INTERLOCK      2'h2
`define PPM_AUX_PULSED         2'h3
`define PPM_PORT_A             1'h1
`define PPM_PORT_B             1'h0
`define PPM_BYTE_RESET         8'h00
`define PPM_CLK_PERIOD_NS      10
`define PPM_PULSE_NS           30
`define PPM_PULSE_CYCLES       ((`PPM_PULSE_NS + `PPM_CLK_PERIOD_NS - 1) / `PPM_CLK_PERIOD_NS)
`define PPM_PULSE_CW           2
`endif

/* verilog/ppm_pkg.sv */
// types of the parallel port mode selector
// assumes ppm_defines.svh is on the include path
`include "ppm_defines.svh"
package ppm_pkg;
    typedef enum logic [1:0] {
        MODE_UNI8  = `PPM_MODE_UNI8,
        MODE_UNI16 = `PPM_MODE_UNI16,
        MODE_BID8  = `PPM_MODE_BID8,
        MODE_BID16 = `PPM_MODE_BID16
    } ppm_mode_t;
    typedef enum logic [1:0] {
        AUX_STATUS    = `PPM_AUX_STATUS,
        AUX_GPOUT     = `PPM_AUX_GPOUT,
        AUX_INTERLOCK = `PPM_AUX_INTERLOCK,
        AUX_PULSED    = `PPM_AUX_PULSED
    } ppm_aux_role_t;
    typedef enum logic [1:0] {
        HS_NONE     = 2'h0,
        HS_INBOUND  = 2'h1,
        HS_OUTBOUND = 2'h2
    } ppm_hs_t;
    typedef struct packed {
        logic inLatch;
        logic outDbl;
        logic latchSrc;
        logic ackSrc;
        logic bidir;
    } ppm_cfg_t;
    typedef struct packed {
        logic [1:0]  mask;
        logic [15:0] word;
    } ppm_entry_t;
endpackage : ppm_pkg

/* verilog/ppm_stream_if.sv */
// valid/ready carrier for latched input words between the selector and its buffer
// assumes ppm_pkg is compiled first
`timescale 1ns/1ns
interface ppm_stream_if;
    logic                 valid;
    logic                 ready;
    ppm_pkg::ppm_entry_t  data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : ppm_stream_if

/* verilog/ppm_top.sv */
// parallel port mode selector: two byte ports, four handshake pins, host word path
// assumes synchronous pins and a host that follows valid/ready
`timescale 1ns/1ns
`include "ppm_defines.svh"
module ppm_top (
    input  wire logic         ref_clk,
    input  wire logic         rst,
    input  wire logic [1:0]   portMode,
    input  wire logic [1:0]   portASubmode,
    input  wire logic [1:0]   portBSubmode,
    input  wire logic [7:0]   portADir,
    input  wire logic [7:0]   portBDir,
    input  wire logic [1:0]   portAAuxRole,
    input  wire logic [1:0]   portBAuxRole,
    input  wire logic         portAAuxLevel,
    input  wire logic         portBAuxLevel,
    input  wire logic [7:0]   portAIn,
    output logic [7:0]        portAOut,
    output logic [7:0]        portAOe,
    input  wire logic [7:0]   portBIn,
    output logic [7:0]        portBOut,
    output logic [7:0]        portBOe,
    input  wire logic         portAStrobeIn,
    input  wire logic         portBStrobeIn,
    input  wire logic         portAAuxIn,
    output logic              portAAuxOut,
    output logic              portAAuxOe,
    input  wire logic         portBAuxIn,
    output logic              portBAuxOut,
    output logic              portBAuxOe,
    input  wire logic         wrValid,
    input  wire logic [15:0]  wrData,
    output logic              wrReady,
    output logic              rdValid,
    output logic [1:0]        rdMask,
    output logic [15:0]       rdData,
    input  wire logic         rdReady,
    output logic [7:0]        portASample,
    output logic [7:0]        portBSample,
    output logic [3:0]        statusEdge
);
    function automatic ppm_pkg::ppm_cfg_t portCfg(input logic [1:0] mode,
        input logic [1:0] subA, input logic [1:0] subB, input logic isA);
        ppm_pkg::ppm_cfg_t c;
        logic [1:0] sub;
        c = '0;
        sub = isA ? subA : subB;
        c.latchSrc = isA;
        c.ackSrc = isA;
        if (mode == ppm_pkg::MODE_UNI8)
        begin
            c.inLatch = ~sub[`PPM_SUB_SIMPLE_BIT] & ~sub[`PPM_SUB_OUTDBL_BIT];
            c.outDbl = ~sub[`PPM_SUB_SIMPLE_BIT] & sub[`PPM_SUB_OUTDBL_BIT];
        end
        else if (mode == ppm_pkg::MODE_UNI16)
        begin
            c.inLatch = ~subB[`PPM_SUB_OUTDBL_BIT];
            c.outDbl = subB[`PPM_SUB_OUTDBL_BIT];
            c.latchSrc = `PPM_PORT_B;
            c.ackSrc = `PPM_PORT_B;
        end
        else if (mode == ppm_pkg::MODE_BID16 || !isA)
        begin
            c.inLatch = 1'b1;
            c.outDbl = 1'b1;
            c.latchSrc = `PPM_PORT_B;
            c.ackSrc = `PPM_PORT_A;
            c.bidir = 1'b1;
        end
        return c;
    endfunction : portCfg

    function automatic ppm_pkg::ppm_hs_t hsKind(input logic [1:0] mode, input logic isA,
        input ppm_pkg::ppm_cfg_t c);
        if (mode == ppm_pkg::MODE_UNI16 && isA)
            return ppm_pkg::HS_NONE;
        else if (mode == ppm_pkg::MODE_BID8 || mode == ppm_pkg::MODE_BID16)
            return isA ? ppm_pkg::HS_OUTBOUND : ppm_pkg::HS_INBOUND;
        else if (c.inLatch)
            return ppm_pkg::HS_INBOUND;
        else if (c.outDbl)
            return ppm_pkg::HS_OUTBOUND;
        return ppm_pkg::HS_NONE;
    endfunction : hsKind

    ppm_pkg::ppm_cfg_t          cfg [1:0];
    ppm_pkg::ppm_hs_t           hs [1:0];
    logic [1:0][7:0]            pinIn;
    logic [1:0][7:0]            dirIn;
    logic [1:0][7:0]            latchQ;
    logic [1:0][7:0]            holdQ;
    logic [1:0][7:0]            outQ;
    logic [1:0][7:0]            oeQ;
    logic [1:0][7:0]            next_oe;
    logic [1:0][1:0]            auxRole;
    logic [1:0][`PPM_PULSE_CW-1:0] pulseCnt;
    logic [1:0]                 strobeIn;
    logic [1:0]                 strobePrev;
    logic [1:0]                 auxIn;
    logic [1:0]                 auxPrev;
    logic [1:0]                 auxLevel;
    logic [1:0]                 sEdge;
    logic [1:0]                 aEdge;
    logic [1:0]                 latchEv;
    logic [1:0]                 ackEv;
    logic [1:0]                 latchFull;
    logic [1:0]                 holdFull;
    logic [1:0]                 outFull;
    logic [1:0]                 next_holdFull;
    logic [1:0]                 next_outFull;
    logic [1:0]                 load;
    logic [1:0]                 dblMask;
    logic [1:0]                 strobeUsed;
    logic [1:0]                 watch;
    logic [1:0]                 trig;
    logic [1:0]                 pulsed;
    logic [1:0]                 inter;
    logic [1:0]                 auxOutQ;
    logic [1:0]                 auxOeQ;
    logic [1:0]                 next_auxOut;
    logic [1:0]                 next_auxOe;
    logic [1:0]                 pushMask;
    logic                       push;
    logic                       accept;
    logic                       bidirMode;
    ppm_stream_if               inIf ();
    ppm_stream_if               outIf ();

    assign pinIn = {portAIn, portBIn};
    assign dirIn = {portADir, portBDir};
    assign auxRole = {portAAuxRole, portBAuxRole};
    assign strobeIn = {portAStrobeIn, portBStrobeIn};
    assign auxIn = {portAAuxIn, portBAuxIn};
    assign auxLevel = {portAAuxLevel, portBAuxLevel};
    assign cfg[1] = portCfg(portMode, portASubmode, portBSubmode, `PPM_PORT_A);
    assign cfg[0] = portCfg(portMode, portASubmode, portBSubmode, `PPM_PORT_B);
    assign bidirMode = portMode[1];
    assign sEdge = strobeIn & ~strobePrev;
    assign aEdge = auxIn & ~auxPrev;
    assign accept = wrValid & wrReady;
    assign pushMask = latchFull & {cfg[1].inLatch, cfg[0].inLatch};
    assign push = inIf.valid & inIf.ready;
    assign inIf.valid = |pushMask;
    assign inIf.data = {pushMask, latchQ[1], latchQ[0]};
    assign outIf.ready = rdReady;
    assign rdValid = outIf.valid;
    assign rdMask = outIf.data.mask;
    assign rdData = outIf.data.word;
    assign portAOut = outQ[1];
    assign portBOut = outQ[0];
    assign portAOe = oeQ[1];
    assign portBOe = oeQ[0];
    assign portAAuxOut = auxOutQ[1];
    assign portBAuxOut = auxOutQ[0];
    assign portAAuxOe = auxOeQ[1];
    assign portBAuxOe = auxOeQ[0];

    ppm_buffer u_buffer (
        .ref_clk (ref_clk),
        .rst     (rst),
        .inPort  (inIf),
        .outPort (outIf)
    );

    // strobe and output-path next state
    always_comb
    begin
        strobeUsed = 2'h0;
        for (int p = 0; p < 2; p++)
        begin
            latchEv[p] = sEdge[cfg[p].latchSrc];
            ackEv[p] = sEdge[cfg[p].ackSrc];
            dblMask[p] = cfg[p].outDbl;
            load[p] = cfg[p].outDbl & holdFull[p] & (~outFull[p] | ackEv[p]);
            next_holdFull[p] = holdFull[p];
            next_outFull[p] = outFull[p];
            if (!cfg[p].outDbl)
            begin
                next_holdFull[p] = 1'b0;
                next_outFull[p] = 1'b0;
            end
            else if (accept)
                next_holdFull[p] = 1'b1;
            else if (load[p])
            begin
                next_holdFull[p] = 1'b0;
                next_outFull[p] = 1'b1;
            end
            else if (ackEv[p])
                next_outFull[p] = 1'b0;
            if (cfg[p].inLatch)
                strobeUsed[cfg[p].latchSrc] = 1'b1;
            if (cfg[p].outDbl || cfg[p].bidir)
                strobeUsed[cfg[p].ackSrc] = 1'b1;
            next_oe[p] = cfg[p].bidir ? {8{strobeIn[1]}} : dirIn[p];
        end
    end

    // handshake pin roles
    always_comb
    begin
        for (int a = 0; a < 2; a++)
        begin
            watch[a] = (portMode == ppm_pkg::MODE_UNI8) ? a[0] : `PPM_PORT_B;
            hs[a] = hsKind(portMode, a[0], cfg[watch[a]]);
            trig[a] = (hs[a] == ppm_pkg::HS_INBOUND) ? push & pushMask[watch[a]]
                    : (hs[a] == ppm_pkg::HS_OUTBOUND) & load[watch[a]];
            pulsed[a] = (hs[a] != ppm_pkg::HS_NONE) && auxRole[a] == ppm_pkg::AUX_PULSED;
            inter[a] = (hs[a] != ppm_pkg::HS_NONE) && !pulsed[a]
                     && (auxRole[a] == ppm_pkg::AUX_INTERLOCK || bidirMode);
            next_auxOe[a] = 1'b1;
            if (pulsed[a])
                next_auxOut[a] = pulseCnt[a] != '0;
            else if (inter[a])
                next_auxOut[a] = (hs[a] == ppm_pkg::HS_INBOUND) ? ~latchFull[watch[a]]
                               : outFull[watch[a]];
            else
            begin
                next_auxOe[a] = auxRole[a] == ppm_pkg::AUX_GPOUT;
                next_auxOut[a] = next_auxOe[a] & auxLevel[a];
            end
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            strobePrev <= 2'h0;
            auxPrev <= 2'h0;
            statusEdge <= 4'h0;
            portASample <= `PPM_BYTE_RESET;
            portBSample <= `PPM_BYTE_RESET;
        end
        else
        begin
            strobePrev <= strobeIn;
            auxPrev <= auxIn;
            statusEdge <= {sEdge[1] & ~strobeUsed[1], aEdge[1] & ~auxOeQ[1],
                           sEdge[0] & ~strobeUsed[0], aEdge[0] & ~auxOeQ[0]};
            portASample <= portAIn;
            portBSample <= portBIn;
        end
    end

    // input latches feeding the buffer
    always_ff @(posedge ref_clk)
    begin
        for (int p = 0; p < 2; p++)
        begin
            if (rst)
            begin
                latchFull[p] <= 1'b0;
                latchQ[p] <= `PPM_BYTE_RESET;
            end
            else if (!cfg[p].inLatch)
                latchFull[p] <= 1'b0;
            else if (latchEv[p] && !latchFull[p])
            begin
                latchFull[p] <= 1'b1;
                latchQ[p] <= pinIn[p];
            end
            else if (push && pushMask[p])
                latchFull[p] <= 1'b0;
        end
    end

    // output registers, single or double buffered
    always_ff @(posedge ref_clk)
    begin
        for (int p = 0; p < 2; p++)
        begin
            if (rst)
            begin
                holdQ[p] <= `PPM_BYTE_RESET;
                outQ[p] <= `PPM_BYTE_RESET;
                oeQ[p] <= 8'h00;
            end
            else
            begin
                oeQ[p] <= next_oe[p];
                if (accept && cfg[p].outDbl)
                    holdQ[p] <= wrData[p*8 +: 8];
                if (accept && !cfg[p].outDbl)
                    outQ[p] <= wrData[p*8 +: 8];
                else if (load[p])
                    outQ[p] <= holdQ[p];
            end
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            holdFull <= 2'h0;
            outFull <= 2'h0;
            wrReady <= 1'b0;
        end
        else
        begin
            holdFull <= next_holdFull;
            outFull <= next_outFull;
            wrReady <= ~|(next_holdFull & dblMask);
        end
    end

    always_ff @(posedge ref_clk)
    begin
        for (int a = 0; a < 2; a++)
        begin
            if (rst)
            begin
                pulseCnt[a] <= '0;
                auxOutQ[a] <= 1'b0;
                auxOeQ[a] <= 1'b0;
            end
            else
            begin
                auxOutQ[a] <= next_auxOut[a];
                auxOeQ[a] <= next_auxOe[a];
                if (trig[a] && pulsed[a])
                    pulseCnt[a] <= `PPM_PULSE_CW'(`PPM_PULSE_CYCLES);
                else if (pulseCnt[a] != '0)
                    pulseCnt[a] <= pulseCnt[a] - 1'b1;
            end
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    sequence latchTakeB;
        cfg[0].inLatch && latchEv[0] && !latchFull[0];
    endsequence
    sequence pulseStartA;
        pulsed[1] && trig[1];
    endsequence
    sequence ackWithHoldB;
        cfg[0].outDbl && holdFull[0] && ackEv[0];
    endsequence

    latch_capture_a: assert property (latchTakeB |=> latchFull[0]
        && latchQ[0] == $past(portBIn)) else $error("input byte not latched");
    single_out_a: assert property (accept && !cfg[1].outDbl |=>
        portAOut == $past(wrData[15:8])) else $error("single output not written");
    dbl_wait_a: assert property (cfg[0].outDbl && outFull[0] && !ackEv[0] |=>
        $stable(portBOut)) else $error("double output moved before acknowledge");
    dbl_load_a: assert property (ackWithHoldB |=> portBOut == $past(holdQ[0]))
        else $error("held byte not moved on acknowledge");
    bidir_drive_a: assert property (cfg[0].bidir && $past(cfg[0].bidir) |->
        portBOe == {8{$past(portAStrobeIn)}}) else $error("drivers not following strobe");
    wide_push_a: assert property (portMode[0] && inIf.valid |-> pushMask == 2'h3)
        else $error("wide word split");
    bit_io_a: assert property (portMode == ppm_pkg::MODE_BID8 && $past(portMode) ==
        ppm_pkg::MODE_BID8 |-> !latchFull[1] && !holdFull[1]) else $error("port A buffered");
    aux_inter_a: assert property (inter[1] && hs[1] == ppm_pkg::HS_OUTBOUND |=>
        portAAuxOut == $past(outFull[watch[1]]) && portAAuxOe) else $error("interlock wrong");
    aux_pulse_a: assert property (pulseStartA ##1 pulsed[1] |=> portAAuxOut[*3])
        else $error("handshake pulse too short");
    gp_out_a: assert property (hs[0] == ppm_pkg::HS_NONE
        && auxRole[0] == ppm_pkg::AUX_GPOUT |=> portBAuxOe
        && portBAuxOut == $past(portBAuxLevel)) else $error("aux output level wrong");
    status_edge_a: assert property (sEdge[1] && !strobeUsed[1] |=> statusEdge[3])
        else $error("strobe status edge lost");
endmodule : ppm_top
